// file: inc/flash_seq_regs.svh
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// Opcodes
`define OP_PROG_THRU_BUF 8'h02
`define OP_PAGE_ERASE 8'h81
`define OP_BLOCK_ERASE 8'h50
`define OP_SECTOR_ERASE 8'h7c

// Command framing
`define CMD_ADDR_DONE_BYTE 3'h3
`define CMD_FIRST_DATA_BYTE 3'h4

// Page geometry
`define PAGE_BYTES_STD 9'h108
`define PAGE_BYTES_BIN 9'h100
`define BLOCK_LAST_OFS 10'h007
`define SECTOR0A_LAST_PAGE 10'h007
`define SECTOR0B_FIRST_PAGE 10'h008
`define SECTOR_LAST_OFS 10'h07f

// Timing
`define CLK_PERIOD_NS 10
`define PER_BYTE_PROGRAM_TIME_NS 8000
`define PAGE_ERASE_TIME_LIMIT_NS 40000
`define CYCLES_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: inc/flash_seq_pkg.sv
package flash_seq_pkg;

   typedef enum logic {
      ARR_PROGRAM,
      ARR_ERASE
   } arr_op_e;

   // One array step: program a byte or erase a page
   typedef struct packed {
      logic valid;
      arr_op_e op;
      logic [9:0] page;
      logic [8:0] col;
      logic [7:0] data;
   } arr_cmd_s;

   // One byte bound for the page buffer
   typedef struct packed {
      logic [8:0] col;
      logic [7:0] data;
   } buf_wr_s;

endpackage

// file: hdl/flash_seq.sv
// Operation
// R1: Opcode 02h, 264-byte pages: 5 dummy, 10 page bits, 9 buffer byte bits.
// R2: Opcode 02h, 256-byte pages: 6 dummy, 10 page, 8 byte bits, linear address.
// R3: Data bytes fill buffer at successive locations, wrapping to zero past the end.
// R4: Chip select rising starts programming only the loaded bytes of the page.
// R5: Chip select rising mid-byte aborts the command; nothing is programmed.
// R6: Program time is per-byte time times loaded bytes; busy throughout.
// R7: Each programmed byte is verified; a failure sets the error flag.
// R8: Opcode 81h erases a page; page index sits as for programming.
// R9: Page erase sets the whole page to ones, self-timed, busy throughout.
// R10: Opcode 50h, 264-byte pages: 5 dummy, upper 7 page bits, 12 dummy.
// R11: Opcode 50h, 256-byte pages: 6 dummy, address bits 17..11, 11 dummy.
// R12: Block erase clears eight consecutive pages chosen by upper seven page bits.
// R13: Opcode 7Ch carries sector address within page bits, rest don't care.
// R14: Sector 1-7 erase, 256-byte pages: 6 dummy, bits 17..15, 15 dummy.
// R15: Page bits 0000000 select 0a, 0000001 0b, else top three bits select 1-7.
// R16: One sector erased per command; any address inside selects it; busy throughout.
// R17: Every erased location is verified; a failure sets the error flag.
// R18: Host must pre-erase locations before programming without erase.
// R19: Host polls busy before the next command and checks the error flag.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"

module flash_byte_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 4
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   assign o_ready = (count_q != (AW+1)'(DEPTH));
   assign o_valid = (count_q != '0);
   assign o_data = mem_q[rd_ptr_q];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= i_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module flash_seq #(
   parameter int BYTE_PROG_CYC = `CYCLES_UP(`PER_BYTE_PROGRAM_TIME_NS),
   parameter int PAGE_ERASE_CYC = `CYCLES_UP(`PAGE_ERASE_TIME_LIMIT_NS),
   parameter int FIFO_DEPTH = 4
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   input wire logic i_binary_page,
   input wire logic i_arr_ok,
   output flash_seq_pkg::arr_cmd_s o_arr_cmd,
   output logic o_busy,
   output logic o_erase_program_error_flag
);
   typedef enum logic [2:0] {S_IDLE, S_FLUSH, S_SCAN, S_ISSUE, S_WAIT, S_CHECK} seq_state_e;

   seq_state_e state_q;
   logic [2:0] sclk_q;
   logic [2:0] cs_n_q;
   logic [1:0] mosi_q;
   logic [1:0] bin_q;
   logic [6:0] shift_q;
   logic [2:0] bitcnt_q;
   logic [2:0] bytecnt_q;
   logic [7:0] opcode_q;
   logic [23:0] addr_q;
   logic cmd_ok_q;
   logic drop_q;
   logic addr_done_q;
   logic [8:0] wr_col_q;
   logic [7:0] buf_mem_q [`PAGE_BYTES_STD];
   logic [`PAGE_BYTES_STD-1:0] loaded_q;
   logic [9:0] page_q;
   logic [9:0] last_page_q;
   logic [8:0] col_q;
   logic is_prog_q;
   logic [23:0] timer_q;
   logic sclk_rise;
   logic cs_rise;
   logic cs_fall;
   logic byte_done;
   logic [7:0] byte_w;
   logic [9:0] page_w;
   logic [8:0] col_w;
   logic [8:0] page_bytes_w;
   logic launch;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic drain;
   logic push;
   flash_seq_pkg::buf_wr_s fifo_in;
   flash_seq_pkg::buf_wr_s fifo_out;

   // Pins are asynchronous to i_clk; the third stage only feeds edge detection
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sclk_q <= '0;
         cs_n_q <= 3'h7;
         mosi_q <= '0;
         bin_q <= '0;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], i_sclk};
         cs_n_q <= {cs_n_q[1:0], i_cs_n};
         mosi_q <= {mosi_q[0], i_mosi};
         bin_q <= {bin_q[0], i_binary_page};
      end
   end

   assign sclk_rise = sclk_q[1] && !sclk_q[2] && !cs_n_q[1];
   assign cs_rise = cs_n_q[1] && !cs_n_q[2];
   assign cs_fall = !cs_n_q[1] && cs_n_q[2];
   assign byte_w = {shift_q, mosi_q[1]};
   assign byte_done = sclk_rise && (bitcnt_q == 3'h7);
   assign page_bytes_w = bin_q[1] ? `PAGE_BYTES_BIN : `PAGE_BYTES_STD;
   assign page_w = bin_q[1] ? addr_q[17:8] : addr_q[18:9]; // R1 R2 R8
   assign col_w = bin_q[1] ? {1'b0, addr_q[7:0]} : addr_q[8:0]; // R1 R2
   assign push = byte_done && cmd_ok_q && (opcode_q == `OP_PROG_THRU_BUF) && (bytecnt_q == `CMD_FIRST_DATA_BYTE);
   assign fifo_in = '{col: wr_col_q, data: byte_w};
   // Buffer writes stall while the array is busy, so the FIFO can back up
   assign drain = (state_q == S_IDLE) || (state_q == S_FLUSH);
   // A mid-byte chip select release never launches anything
   assign launch = cs_rise && cmd_ok_q && (state_q == S_IDLE) && (bitcnt_q == 3'h0) // R5
      && (bytecnt_q == `CMD_FIRST_DATA_BYTE);

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         shift_q <= '0;
         bitcnt_q <= '0;
         bytecnt_q <= '0;
         opcode_q <= '0;
         addr_q <= '0;
         addr_done_q <= 1'b0;
      end
      else
      begin
         addr_done_q <= byte_done && (bytecnt_q == `CMD_ADDR_DONE_BYTE);
         if (cs_fall)
         begin
            bitcnt_q <= '0;
            bytecnt_q <= '0;
         end
         else if (sclk_rise)
         begin
            shift_q <= byte_w[6:0];
            bitcnt_q <= bitcnt_q + 3'h1;
            if (byte_done)
            begin
               if (bytecnt_q != `CMD_FIRST_DATA_BYTE)
               begin
                  bytecnt_q <= bytecnt_q + 3'h1;
               end
               if (bytecnt_q == 3'h0)
               begin
                  opcode_q <= byte_w;
               end
               else if (bytecnt_q != `CMD_FIRST_DATA_BYTE)
               begin
                  addr_q <= {addr_q[15:0], byte_w};
               end
            end
         end
      end
   end

   // Commands arriving while busy are ignored; a full FIFO spoils the program
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cmd_ok_q <= 1'b0;
         drop_q <= 1'b0;
         wr_col_q <= '0;
      end
      else
      begin
         if (cs_fall)
         begin
            cmd_ok_q <= (state_q == S_IDLE);
            drop_q <= 1'b0;
         end
         else if (push && !fifo_in_ready)
         begin
            drop_q <= 1'b1;
         end
         if (addr_done_q)
         begin
            wr_col_q <= col_w;
         end
         else if (push)
         begin
            wr_col_q <= (wr_col_q == page_bytes_w - 9'h1) ? '0 : wr_col_q + 9'h1; // R3
         end
      end
   end

   flash_byte_fifo #(
      .WIDTH($bits(flash_seq_pkg::buf_wr_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_valid(push),
      .o_ready(fifo_in_ready),
      .i_data(fifo_in),
      .o_valid(fifo_out_valid),
      .i_ready(drain),
      .o_data(fifo_out)
   );

   always_ff @(posedge i_clk)
   begin
      if (fifo_out_valid && drain)
      begin
         buf_mem_q[fifo_out.col] <= fifo_out.data; // R3
      end
   end

   // Loaded marks choose which bytes are programmed
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         loaded_q <= '0;
      end
      else
      begin
         if (cs_fall && (state_q == S_IDLE))
         begin
            loaded_q <= '0;
         end
         if (fifo_out_valid && drain)
         begin
            loaded_q[fifo_out.col] <= 1'b1; // R4
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_q <= S_IDLE;
         o_busy <= 1'b0;
         o_erase_program_error_flag <= 1'b0;
         o_arr_cmd <= '0;
         page_q <= '0;
         last_page_q <= '0;
         col_q <= '0;
         is_prog_q <= 1'b0;
         timer_q <= '0;
      end
      else
      begin
         o_arr_cmd.valid <= 1'b0;
         unique case (state_q)
            S_IDLE:
            begin
               if (launch)
               begin
                  state_q <= S_FLUSH;
                  o_busy <= 1'b1;
                  o_erase_program_error_flag <= 1'b0;
                  col_q <= '0;
                  page_q <= page_w;
                  last_page_q <= page_w;
                  is_prog_q <= (opcode_q == `OP_PROG_THRU_BUF);
                  unique case (opcode_q)
                     `OP_PROG_THRU_BUF:
                     begin
                        if (drop_q)
                        begin
                           state_q <= S_IDLE;
                           o_busy <= 1'b0;
                        end
                     end
                     `OP_PAGE_ERASE:
                     begin
                     end
                     `OP_BLOCK_ERASE:
                     begin
                        page_q <= {page_w[9:3], 3'h0}; // R10 R11 R12
                        last_page_q <= {page_w[9:3], 3'h0} + `BLOCK_LAST_OFS; // R12
                     end
                     `OP_SECTOR_ERASE:
                     begin
                        if (page_w[9:7] != 3'h0)
                        begin
                           page_q <= {page_w[9:7], 7'h0}; // R13 R14 R15
                           last_page_q <= {page_w[9:7], 7'h0} + `SECTOR_LAST_OFS; // R16
                        end
                        else if (page_w[9:3] == 7'h0)
                        begin
                           page_q <= '0; // R15
                           last_page_q <= `SECTOR0A_LAST_PAGE;
                        end
                        else
                        begin
                           page_q <= `SECTOR0B_FIRST_PAGE; // R15
                           last_page_q <= `SECTOR_LAST_OFS;
                        end
                     end
                     default:
                     begin
                        state_q <= S_IDLE;
                        o_busy <= 1'b0;
                     end
                  endcase
               end
            end
            S_FLUSH:
            begin
               if (!fifo_out_valid)
               begin
                  state_q <= is_prog_q ? S_SCAN : S_ISSUE;
               end
            end
            S_SCAN:
            begin
               if (col_q == page_bytes_w)
               begin
                  state_q <= S_IDLE;
                  o_busy <= 1'b0;
               end
               else if (loaded_q[col_q])
               begin
                  state_q <= S_ISSUE; // R4
               end
               else
               begin
                  col_q <= col_q + 9'h1;
               end
            end
            S_ISSUE:
            begin
               o_arr_cmd.valid <= 1'b1;
               o_arr_cmd.op <= is_prog_q ? flash_seq_pkg::ARR_PROGRAM : flash_seq_pkg::ARR_ERASE; // R9
               o_arr_cmd.page <= page_q;
               o_arr_cmd.col <= col_q;
               o_arr_cmd.data <= buf_mem_q[col_q];
               timer_q <= 24'(is_prog_q ? BYTE_PROG_CYC - 1 : PAGE_ERASE_CYC - 1); // R6 R9
               state_q <= S_WAIT;
            end
            S_WAIT:
            begin
               timer_q <= timer_q - 24'h1;
               if (timer_q == '0)
               begin
                  state_q <= S_CHECK;
               end
            end
            S_CHECK:
            begin
               if (!i_arr_ok)
               begin
                  o_erase_program_error_flag <= 1'b1; // R7 R17
               end
               if (is_prog_q)
               begin
                  col_q <= col_q + 9'h1;
                  state_q <= S_SCAN;
               end
               else if (page_q == last_page_q)
               begin
                  state_q <= S_IDLE;
                  o_busy <= 1'b0;
               end
               else
               begin
                  page_q <= page_q + 10'h1;
                  state_q <= S_ISSUE;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   sequence s_issue;
      state_q == S_ISSUE;
   endsequence

   a_midbyte_abort: assert property (cs_rise && bitcnt_q != 3'h0 && state_q == S_IDLE |=> !o_busy) // R5
      else $error("mid-byte release started an operation");
   a_prog_loaded_only: assert property (o_arr_cmd.valid && o_arr_cmd.op == flash_seq_pkg::ARR_PROGRAM // R4
      |-> loaded_q[o_arr_cmd.col])
      else $error("unloaded byte programmed");
   a_busy_during_step: assert property (o_arr_cmd.valid |-> o_busy [*3]) // R6 R9 R16
      else $error("busy dropped during array step");
   a_step_spacing: assert property (s_issue ##1 state_q == S_WAIT |=> !o_arr_cmd.valid [*3]) // R6
      else $error("array steps too close");
   a_fail_sets_error: assert property (state_q == S_CHECK && !i_arr_ok |=> o_erase_program_error_flag) // R7 R17
      else $error("failed verify not flagged");
   a_buffer_wrap: assert property (push && !addr_done_q && wr_col_q == page_bytes_w - 9'h1 |=> wr_col_q == 9'h0) // R3
      else $error("buffer pointer did not wrap");
   a_block_range: assert property (launch && opcode_q == `OP_BLOCK_ERASE // R12
      |=> page_q[2:0] == 3'h0 && last_page_q == page_q + `BLOCK_LAST_OFS)
      else $error("block erase range wrong");
   a_sector0a_range: assert property (launch && opcode_q == `OP_SECTOR_ERASE && page_w[9:3] == 7'h0 // R15
      |=> page_q == 10'h0 && last_page_q == `SECTOR0A_LAST_PAGE)
      else $error("sector 0a range wrong");
   a_page_parse: assert property (launch && opcode_q == `OP_PAGE_ERASE && !bin_q[1] // R1 R8
      |=> page_q == addr_q[18:9] && last_page_q == page_q)
      else $error("page index misparsed");
endmodule

// file: testbench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
   input wire logic i_clk,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_mosi
);
   // Half of the 160 ns link period in system clocks
   localparam int HALF = 8;

   initial
   begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end

   task automatic half_wait();
      repeat (HALF) @(negedge i_clk);
   endtask

   // Mode 0 frame; sclk stands still low outside frames
   task automatic send(input logic [7:0] b[$], input int extra);
      int n;
      n = b.size() * 8 + extra;
      @(negedge i_clk);
      o_cs_n <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         o_mosi <= (i / 8 < b.size()) ? b[i / 8][7 - i % 8] : 1'b1;
         half_wait();
         o_sclk <= 1'b1;
         half_wait();
         o_sclk <= 1'b0;
      end
      half_wait();
      o_cs_n <= 1'b1;
      // Deselected line shows the inverse, so a stale bit is never mistaken for data
      o_mosi <= ~o_mosi;
   endtask
endmodule

// file: testbench/tb_flash_seq.sv
`timescale 1ns/1ps
module tb_flash_seq;
   localparam int BYTE_CYC = 4;
   localparam int ERASE_CYC = 6;
   logic i_clk, i_reset_n, i_sclk, i_cs_n, i_mosi, i_binary_page, i_arr_ok;
   flash_seq_pkg::arr_cmd_s o_arr_cmd;
   logic o_busy, o_erase_program_error_flag;
   int miscompares = 0;
   int checked = 0;
   int busy_cyc = 0;
   int bad_page = -1;
   logic [27:0] steps[$];
   logic [27:0] exp_q[$];
   logic [7:0] tx[$];

   flash_seq #(.BYTE_PROG_CYC(BYTE_CYC), .PAGE_ERASE_CYC(ERASE_CYC)) flash_seq_i (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_mosi(i_mosi),
      .i_binary_page(i_binary_page), .i_arr_ok(i_arr_ok), .o_arr_cmd(o_arr_cmd), .o_busy(o_busy),
      .o_erase_program_error_flag(o_erase_program_error_flag));

   spi_host_model spi_host_model_i (.i_clk(i_clk), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_mosi(i_mosi));

   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp_v, input string what);
      checked++;
      if (seen !== exp_v)
      begin
         miscompares++;
         $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp_v);
      end
   endtask

   // Erase steps keep only op and page: other fields hold stale values
   // Array stand-in fails verify only on bad_page, so a single bad page must still flag
   always @(negedge i_clk)
   begin
      i_arr_ok <= (int'(o_arr_cmd.page) != bad_page);
      if (o_busy === 1'b1)
         busy_cyc++;
      if (o_arr_cmd.valid === 1'b1)
      begin
         steps.push_back(o_arr_cmd.op == flash_seq_pkg::ARR_ERASE ? {1'b1, o_arr_cmd.page, 17'h0}
            : {1'b0, o_arr_cmd.page, o_arr_cmd.col, o_arr_cmd.data});
         check(o_busy, 1'b1, "array step while idle");
      end
   end

   function automatic logic [23:0] addr(input logic m, input logic [9:0] p);
      return m ? {6'h3f, p, 8'hff} : {5'h1f, p, 9'h1ff};
   endfunction

   task automatic cmd(input logic [7:0] op, input logic [23:0] a);
      tx.delete();
      tx.push_back(op);
      tx.push_back(a[23:16]);
      tx.push_back(a[15:8]);
      tx.push_back(a[7:0]);
   endtask

   task automatic set_mode(input logic m);
      i_binary_page = m;
      repeat (8) @(negedge i_clk);
   endtask

   // Sends tx, then polls busy until ready before anything else is issued
   task automatic run(input int extra, input logic launch);
      int k;
      steps.delete();
      busy_cyc = 0;
      spi_host_model_i.send(tx, extra);
      k = 0;
      while (o_busy !== 1'b1 && k < 40)
      begin
         @(negedge i_clk);
         k++;
      end
      check(o_busy, launch, "launch");
      k = 0;
      while (o_busy !== 1'b0 && k < 5000)
      begin
         @(negedge i_clk);
         k++;
      end
      check(o_busy, 1'b0, "busy never ends");
   endtask

   task automatic cmp_steps();
      check(steps.size(), exp_q.size(), "step count");
      foreach (exp_q[i])
         check(steps[i], exp_q[i], "array step");
      exp_q.delete();
   endtask

   // Array stand-in treats the page as pre-erased by the host
   task automatic t_program_std();
      set_mode(1'b0);
      bad_page = -1;
      cmd(8'h02, {5'h1f, 10'h155, 9'd262});
      tx.push_back(8'ha1);
      tx.push_back(8'hb2);
      tx.push_back(8'hc3);
      run(0, 1'b1);
      exp_q = '{{1'b0, 10'h155, 9'd0, 8'hc3}, {1'b0, 10'h155, 9'd262, 8'ha1}, {1'b0, 10'h155, 9'd263, 8'hb2}};
      cmp_steps();
      check(busy_cyc >= 264 + 3 * BYTE_CYC && busy_cyc <= 264 + 3 * (BYTE_CYC + 6) + 6, 1'b1, "time");
      check(o_erase_program_error_flag, 1'b0, "error flag");
      $display("test program_std done");
   endtask

   task automatic t_program_bin();
      set_mode(1'b1);
      bad_page = int'(10'h2aa);
      cmd(8'h02, {6'h3f, 10'h2aa, 8'hff});
      tx.push_back(8'h11);
      tx.push_back(8'h22);
      run(0, 1'b1);
      exp_q = '{{1'b0, 10'h2aa, 9'd0, 8'h22}, {1'b0, 10'h2aa, 9'd255, 8'h11}};
      cmp_steps();
      check(o_erase_program_error_flag, 1'b1, "program failure");
      bad_page = -1;
      $display("test program_bin done");
   endtask

   task automatic t_abort();
      cmd(8'h02, {6'h00, 10'h001, 8'h10});
      tx.push_back(8'h5a);
      run(3, 1'b0);
      check(steps.size(), 0, "aborted program wrote");
      $display("test abort done");
   endtask

   task automatic t_page_erase();
      logic [9:0] pg[2] = '{10'h0a5, 10'h3ff};
      for (int m = 0; m < 2; m++)
      begin
         set_mode(m[0]);
         cmd(8'h81, addr(m[0], pg[m]));
         run(0, 1'b1);
         exp_q.push_back({1'b1, pg[m], 17'h0});
         cmp_steps();
         check(o_erase_program_error_flag, 1'b0, "flag cleared");
      end
      $display("test page_erase done");
   endtask

   task automatic t_block_erase();
      for (int m = 0; m < 2; m++)
      begin
         set_mode(m[0]);
         bad_page = m[0] ? int'(10'h0fb) : -1;
         cmd(8'h50, addr(m[0], 10'h0fd));
         run(0, 1'b1);
         for (int p = 10'h0f8; p <= 10'h0ff; p++)
            exp_q.push_back({1'b1, p[9:0], 17'h0});
         cmp_steps();
         check(o_erase_program_error_flag, m[0], "erase verify");
      end
      bad_page = -1;
      $display("test block_erase done");
   endtask

   task automatic t_sector_erase();
      logic [9:0] pg[4] = '{10'h005, 10'h070, 10'h2c0, 10'h3ff};
      int first[4] = '{0, 8, 640, 896};
      int last[4] = '{7, 127, 767, 1023};
      for (int s = 0; s < 4; s++)
      begin
         set_mode(s[0]);
         cmd(8'h7c, addr(s[0], pg[s]));
         run(0, 1'b1);
         for (int p = first[s]; p <= last[s]; p++)
            exp_q.push_back({1'b1, p[9:0], 17'h0});
         cmp_steps();
      end
      $display("test sector_erase done");
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #400000;
      miscompares++;
      $display("Error at %0t ns: watchdog expired", $time);
      summarize();
   end

   initial
   begin
      i_reset_n = 1'b0;
      i_binary_page = 1'b0;
      repeat (20) @(negedge i_clk);
      i_reset_n = 1'b1;
      repeat (5) @(negedge i_clk);
      t_program_std();
      t_program_bin();
      t_abort();
      t_page_erase();
      t_block_erase();
      t_sector_erase();
      summarize();
   end
endmodule
